// ===== rtl/sdb_pkg.sv
// ==================================================================
// serial dma buffer configuration constants
package sdb_pkg;
   localparam int SDB_AW = 18;
   localparam int SDB_DW = 32;
   localparam int SDB_ADR_W = 13;
   localparam int SDB_IRQ_W = 15;
   localparam int SDB_NCFG = 6;
   typedef logic [15:0] sdb_idx_t;
   // ===============================================================
   // register indices, byte address is four times the index
   localparam sdb_idx_t SDB_IDX_RX_B_START = 16'h4484;
   localparam sdb_idx_t SDB_IDX_RX_B_END = 16'h4486;
   localparam sdb_idx_t SDB_IDX_TX_A_START = 16'h4488;
   localparam sdb_idx_t SDB_IDX_TX_A_END = 16'h448A;
   localparam sdb_idx_t SDB_IDX_TX_B_START = 16'h448C;
   localparam sdb_idx_t SDB_IDX_TX_B_END = 16'h448E;
   localparam sdb_idx_t SDB_IDX_RX_A_CNT = 16'h4490;
   localparam sdb_idx_t SDB_IDX_RX_B_CNT = 16'h4492;
   localparam sdb_idx_t SDB_IDX_RX_A_ERR = 16'h449A;
   localparam sdb_idx_t SDB_IDX_RX_B_ERR = 16'h449C;
   localparam sdb_idx_t SDB_IDX_DMA_CTRL = 16'h44A0;
   localparam sdb_idx_t SDB_IDX_PEND = 16'h460C;
   localparam sdb_idx_t SDB_IDX_PEND_CLR = 16'h460E;
   localparam sdb_idx_t SDB_IDX_IRQ_EN = 16'h4624;
   // ===============================================================
   // fields and reset values
   localparam logic [15:0] SDB_ADDR_FIXED = 16'h6000;
   localparam logic [12:0] SDB_ADDR_RST = 13'h0000;
   localparam logic [14:0] SDB_IRQ_RST = 15'h0000;
   localparam int SDB_CTRL_RX_RST = 0;
   localparam int SDB_BIT_RX_A_ULD = 9;
   localparam int SDB_BIT_RX_B_ULD = 10;
   localparam int SDB_BIT_TX_A_ULD = 11;
   localparam int SDB_BIT_TX_B_ULD = 12;
   localparam int SDB_BIT_NACK = 8;
   localparam int SDB_BIT_CMD_DONE = 7;
   localparam int SDB_BIT_TX_DONE = 6;
   localparam int SDB_BIT_RX_DONE = 5;
   localparam int SDB_BIT_FRAME = 13;
   localparam int SDB_BIT_PARITY = 14;
   localparam logic [1:0] SDB_RESP_OKAY = 2'h0;
   localparam logic [1:0] SDB_RESP_DECERR = 2'h3;
endpackage

// ===== rtl/sdb_top.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module sdb_top
   import sdb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [SDB_AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [SDB_DW-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [SDB_AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [SDB_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [SDB_IRQ_W-1:0] event_in,
   input wire logic [1:0] rx_byte_wr,
   input wire logic rx_byte_err,
   input wire logic [1:0] rx_buf_load,
   input wire logic [1:0] rx_buf_unload,
   output logic [SDB_ADR_W-1:0] rx_buf_b_start,
   output logic [SDB_ADR_W-1:0] rx_buf_b_end,
   output logic [SDB_ADR_W-1:0] tx_buf_a_start,
   output logic [SDB_ADR_W-1:0] tx_buf_a_end,
   output logic [SDB_ADR_W-1:0] tx_buf_b_start,
   output logic [SDB_ADR_W-1:0] tx_buf_b_end,
   output logic [SDB_ADR_W-1:0] rx_buf_a_byte_count,
   output logic [SDB_ADR_W-1:0] rx_buf_b_byte_count,
   output logic rx_dma_rst,
   output logic irq
);
   // ===============================================================
   // storage
   logic [SDB_ADR_W-1:0] cfg_reg [0:SDB_NCFG-1];
   logic [SDB_ADR_W-1:0] cnt_reg [0:1];
   logic [SDB_ADR_W-1:0] err_reg [0:1];
   logic [1:0] armed_reg;
   logic [SDB_IRQ_W-1:0] pend_reg;
   logic [SDB_IRQ_W-1:0] en_reg;
   logic rx_rst_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [SDB_DW-1:0] rdata_reg;
   logic wr_go;
   logic rd_go;
   logic [15:0] wr_idx;
   logic [15:0] rd_idx;
   logic [15:0] wr_val;
   logic [15:0] rd_val;
   logic rd_hit;
   logic wr_hit;
   logic [SDB_IRQ_W-1:0] pend_set;
   logic [SDB_IRQ_W-1:0] pend_clr;

   function automatic int cfg_slot(input logic [15:0] idx);
      if (idx == SDB_IDX_RX_B_START) begin
         return 0;
      end else if (idx == SDB_IDX_RX_B_END) begin
         return 1;
      end else if (idx == SDB_IDX_TX_A_START) begin
         return 2;
      end else if (idx == SDB_IDX_TX_A_END) begin
         return 3;
      end else if (idx == SDB_IDX_TX_B_START) begin
         return 4;
      end else if (idx == SDB_IDX_TX_B_END) begin
         return 5;
      end else begin
         return -1;
      end
   endfunction

   // ===============================================================
   // axi4-lite handshake, address and data taken together
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign rd_go = s_axi_arvalid && !rvalid_reg;
   assign s_axi_arready = rd_go;
   assign wr_idx = s_axi_awaddr[SDB_AW-1:2];
   assign rd_idx = s_axi_araddr[SDB_AW-1:2];
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;

   // byte lanes 0 and 1 merged over zero
   always_comb begin
      wr_val = 16'h0000;
      if (s_axi_wstrb[0]) begin
         wr_val[7:0] = s_axi_wdata[7:0];
      end
      if (s_axi_wstrb[1]) begin
         wr_val[15:8] = s_axi_wdata[15:8];
      end
      wr_hit = (cfg_slot(wr_idx) >= 0) || (wr_idx == SDB_IDX_IRQ_EN)
         || (wr_idx == SDB_IDX_PEND_CLR) || (wr_idx == SDB_IDX_DMA_CTRL);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= SDB_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_hit ? SDB_RESP_OKAY : SDB_RESP_DECERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // ===============================================================
   // address registers, 13 writable bits each
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < SDB_NCFG; i++) begin
            cfg_reg[i] <= SDB_ADDR_RST;
         end
      end else if (wr_go) begin
         for (int i = 0; i < SDB_NCFG; i++) begin
            if (cfg_slot(wr_idx) == i) begin
               if (s_axi_wstrb[0]) begin
                  cfg_reg[i][7:0] <= wr_val[7:0];
               end
               if (s_axi_wstrb[1]) begin
                  cfg_reg[i][12:8] <= wr_val[12:8];
               end
            end
         end
      end
   end

   assign rx_buf_b_start = cfg_reg[0];
   assign rx_buf_b_end = cfg_reg[1];
   assign tx_buf_a_start = cfg_reg[2];
   assign tx_buf_a_end = cfg_reg[3];
   assign tx_buf_b_start = cfg_reg[4];
   assign tx_buf_b_end = cfg_reg[5];

   // ===============================================================
   // interrupt enable, pending flags and request
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         en_reg <= SDB_IRQ_RST;
      end else if (wr_go && wr_idx == SDB_IDX_IRQ_EN) begin
         if (s_axi_wstrb[0]) begin
            en_reg[7:0] <= wr_val[7:0];
         end
         if (s_axi_wstrb[1]) begin
            en_reg[14:8] <= wr_val[14:8];
         end
      end
   end

   always_comb begin
      pend_set = event_in;
      pend_set[SDB_BIT_RX_A_ULD] = event_in[SDB_BIT_RX_A_ULD]
         || rx_buf_unload[0];
      pend_set[SDB_BIT_RX_B_ULD] = event_in[SDB_BIT_RX_B_ULD]
         || rx_buf_unload[1];
      pend_clr = SDB_IRQ_RST;
      if (wr_go && wr_idx == SDB_IDX_PEND_CLR) begin
         pend_clr = wr_val[SDB_IRQ_W-1:0];
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pend_reg <= SDB_IRQ_RST;
      end else begin
         pend_reg <= (pend_reg & ~pend_clr) | pend_set;
      end
   end

   assign irq = |(pend_reg & en_reg);

   // self-clearing receive dma reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_rst_reg <= 1'b0;
      end else begin
         rx_rst_reg <= wr_go && wr_idx == SDB_IDX_DMA_CTRL
            && s_axi_wstrb[0] && s_axi_wdata[SDB_CTRL_RX_RST];
      end
   end
   assign rx_dma_rst = rx_rst_reg;

   // ===============================================================
   // receive byte counters and first error capture
   for (genvar g = 0; g < 2; g++) begin : g_rx
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            cnt_reg[g] <= SDB_ADDR_RST;
         end else if (rx_rst_reg || rx_buf_unload[g]) begin
            cnt_reg[g] <= SDB_ADDR_RST;
         end else if (rx_byte_wr[g]) begin
            cnt_reg[g] <= cnt_reg[g] + 13'h0001;
         end
      end

      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            armed_reg[g] <= 1'b1;
            err_reg[g] <= SDB_ADDR_RST;
         end else if (rx_rst_reg || rx_buf_load[g]) begin
            armed_reg[g] <= 1'b1;
            err_reg[g] <= SDB_ADDR_RST;
         end else if (rx_byte_wr[g] && rx_byte_err && armed_reg[g]) begin
            armed_reg[g] <= 1'b0;
            err_reg[g] <= cnt_reg[g];
         end
      end

      a_err_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
         !armed_reg[g] && !rx_rst_reg && !rx_buf_load[g]
         |=> $stable(err_reg[g]))
         else $error("error offset changed after capture");

      a_err_capture: assert property (@(posedge clk_sys) disable iff (!rst_n)
         armed_reg[g] && rx_byte_wr[g] && rx_byte_err && !rx_rst_reg
         && !rx_buf_load[g] |=> err_reg[g] == $past(cnt_reg[g]))
         else $error("first error offset not captured");

      a_err_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
         armed_reg[g] |-> err_reg[g] == SDB_ADDR_RST)
         else $error("error offset nonzero with no error");

      a_rearm_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
         rx_rst_reg || rx_buf_load[g] |=> armed_reg[g])
         else $error("capture not rearmed");

      a_cnt_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
         rx_byte_wr[g] && !rx_buf_unload[g] && !rx_rst_reg
         |=> cnt_reg[g] == $past(cnt_reg[g]) + 13'h0001)
         else $error("byte counter did not advance");

      a_cnt_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
         rx_buf_unload[g] |=> cnt_reg[g] == SDB_ADDR_RST)
         else $error("byte counter did not wrap");

      c_err_kept: cover property (@(posedge clk_sys) disable iff (!rst_n)
         rx_byte_wr[g] && rx_byte_err ##1 !armed_reg[g]
         ##[1:20] rx_byte_wr[g] && rx_byte_err);
   end

   assign rx_buf_a_byte_count = cnt_reg[0];
   assign rx_buf_b_byte_count = cnt_reg[1];

   // ===============================================================
   // read path
   always_comb begin
      rd_val = 16'h0000;
      rd_hit = 1'b1;
      if (cfg_slot(rd_idx) >= 0) begin
         rd_val = SDB_ADDR_FIXED | {3'h0, cfg_reg[cfg_slot(rd_idx)]};
      end else if (rd_idx == SDB_IDX_RX_A_CNT) begin
         rd_val = {3'h0, cnt_reg[0]};
      end else if (rd_idx == SDB_IDX_RX_B_CNT) begin
         rd_val = {3'h0, cnt_reg[1]};
      end else if (rd_idx == SDB_IDX_RX_A_ERR) begin
         rd_val = {3'h0, err_reg[0]};
      end else if (rd_idx == SDB_IDX_RX_B_ERR) begin
         rd_val = {3'h0, err_reg[1]};
      end else if (rd_idx == SDB_IDX_PEND) begin
         rd_val = {1'b0, pend_reg};
      end else if (rd_idx == SDB_IDX_IRQ_EN) begin
         rd_val = {1'b0, en_reg};
      end else if (rd_idx == SDB_IDX_PEND_CLR) begin
         rd_val = 16'h0000;
      end else if (rd_idx == SDB_IDX_DMA_CTRL) begin
         rd_val = 16'h0000;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_reg <= 1'b0;
         rresp_reg <= SDB_RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else if (rd_go) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= rd_hit ? SDB_RESP_OKAY : SDB_RESP_DECERR;
         rdata_reg <= {16'h0000, rd_val};
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ===============================================================
   // checks
   a_cfg_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_go && wr_idx == SDB_IDX_RX_B_START && s_axi_wstrb[1:0] == 2'h3
      |=> rx_buf_b_start == $past(s_axi_wdata[12:0]))
      else $error("start address not written");

   a_tx_b_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_go && wr_idx == SDB_IDX_TX_B_END && s_axi_wstrb[1:0] == 2'h3
      |=> tx_buf_b_end == $past(s_axi_wdata[12:0]))
      else $error("tx b end address not written");

   a_en_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_go && wr_idx == SDB_IDX_IRQ_EN && s_axi_wstrb[1:0] == 2'h3
      |=> en_reg == $past(s_axi_wdata[14:0]))
      else $error("enable register not written");

   a_pend_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      event_in[SDB_BIT_PARITY] |=> pend_reg[SDB_BIT_PARITY])
      else $error("pending flag lost its event");

   a_irq_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (pend_reg[SDB_BIT_NACK] && en_reg[SDB_BIT_NACK] |-> irq)
      and (pend_reg == SDB_IRQ_RST |-> !irq))
      else $error("interrupt level wrong");

   a_bresp_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");

   a_rresp_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read response dropped");

   a_rst_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_dma_rst |=> !rx_dma_rst)
      else $error("receive dma reset not a single pulse");

   a_irq_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (pend_reg & en_reg) == SDB_IRQ_RST |-> !irq)
      else $error("interrupt raised while masked");

   a_unload_pend: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_buf_unload[1] |=> pend_reg[SDB_BIT_RX_B_ULD])
      else $error("unload did not set pending flag");

   c_irq_raise: cover property (@(posedge clk_sys) disable iff (!rst_n)
      !irq ##1 irq);
   c_decerr: cover property (@(posedge clk_sys) disable iff (!rst_n)
      s_axi_rvalid && s_axi_rresp == SDB_RESP_DECERR);
   c_rx_rst: cover property (@(posedge clk_sys) disable iff (!rst_n)
      rx_rst_reg);
endmodule
`default_nettype wire

// ===== verification/sdb_rx_src.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================================
// receive dma side stand-in: byte stores, loads, unloads, events
module sdb_rx_src
   import sdb_pkg::*;
(
   input wire logic clk_sys,
   output logic [SDB_IRQ_W-1:0] event_in,
   output logic [1:0] rx_byte_wr,
   output logic rx_byte_err,
   output logic [1:0] rx_buf_load,
   output logic [1:0] rx_buf_unload
);
   initial begin
      event_in = '0;
      rx_byte_wr = 2'h0;
      rx_byte_err = 1'h0;
      rx_buf_load = 2'h0;
      rx_buf_unload = 2'h0;
   end
   // each pulse lasts one cycle and is dropped at the following edge
   task automatic put(input int b, input logic e);
      @(posedge clk_sys);
      rx_byte_wr[b] <= 1'h1;
      rx_byte_err <= e;
      @(posedge clk_sys);
      rx_byte_wr <= 2'h0;
      rx_byte_err <= 1'h0;
   endtask
   task automatic swap(input int b, input logic ld);
      @(posedge clk_sys);
      if (ld) rx_buf_load[b] <= 1'h1;
      else rx_buf_unload[b] <= 1'h1;
      @(posedge clk_sys);
      rx_buf_load <= 2'h0;
      rx_buf_unload <= 2'h0;
   endtask
   task automatic ev(input int k);
      @(posedge clk_sys);
      event_in[k] <= 1'h1;
      @(posedge clk_sys);
      event_in <= '0;
   endtask
endmodule
`default_nettype wire

// ===== verification/serial_dma_buffer_config_bench.sv
`timescale 1ns/100ps
`default_nettype none
module serial_dma_buffer_config_bench
   import sdb_pkg::*;
;
   localparam sdb_idx_t CIX [6] = '{SDB_IDX_RX_B_START, SDB_IDX_RX_B_END,
      SDB_IDX_TX_A_START, SDB_IDX_TX_A_END, SDB_IDX_TX_B_START,
      SDB_IDX_TX_B_END};
   logic clk_sys, rst_n;
   logic [SDB_AW-1:0] awaddr, araddr;
   logic [SDB_DW-1:0] wdata, rdata;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, bwr, ld, uld, rs;
   logic [SDB_IRQ_W-1:0] ev;
   logic berr;
   logic [3:0] strb;
   logic dma_rst;
   int dma_rsts = 0;
   logic [SDB_ADR_W-1:0] cfg [6];
   logic [SDB_ADR_W-1:0] cnt [2];
   logic [31:0] rv;
   int mismatches, checked;
   sdb_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_in(ev),
      .rx_byte_wr(bwr), .rx_byte_err(berr), .rx_buf_load(ld),
      .rx_buf_unload(uld), .rx_buf_b_start(cfg[0]), .rx_buf_b_end(cfg[1]),
      .tx_buf_a_start(cfg[2]), .tx_buf_a_end(cfg[3]),
      .tx_buf_b_start(cfg[4]), .tx_buf_b_end(cfg[5]),
      .rx_buf_a_byte_count(cnt[0]), .rx_buf_b_byte_count(cnt[1]),
      .rx_dma_rst(dma_rst), .irq(irq));
   sdb_rx_src i_src (.clk_sys(clk_sys), .event_in(ev), .rx_byte_wr(bwr),
      .rx_byte_err(berr), .rx_buf_load(ld), .rx_buf_unload(uld));
   // counts receive dma reset pulses seen at rising edges
   always @(posedge clk_sys) begin
      if (dma_rst === 1'h1) begin
         dma_rsts++;
      end
   end
   // ===============================================================
   // checking and bus tasks
   task automatic chk(input logic [31:0] s, e, input string w);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", w, e, s);
      end
   endtask
   task automatic close_out;
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ready is looked at mid-cycle, the next rising edge is the handshake
   task automatic wr(input sdb_idx_t i, input logic [15:0] d);
      @(posedge clk_sys);
      awaddr <= {i, 2'h0};
      wdata <= {16'h0000, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      @(negedge clk_sys);
      while ((awready & wready) !== 1'h1) @(negedge clk_sys);
      @(posedge clk_sys);
      awvalid <= 1'h0;
      wvalid <= 1'h0;
      bready <= 1'h1;
      @(negedge clk_sys);
      while (bvalid !== 1'h1) @(negedge clk_sys);
      rs = bresp;
      @(posedge clk_sys);
      bready <= 1'h0;
   endtask
   task automatic rd(input sdb_idx_t i);
      @(posedge clk_sys);
      araddr <= {i, 2'h0};
      arvalid <= 1'h1;
      @(negedge clk_sys);
      while (arready !== 1'h1) @(negedge clk_sys);
      @(posedge clk_sys);
      arvalid <= 1'h0;
      rready <= 1'h1;
      @(negedge clk_sys);
      while (rvalid !== 1'h1) @(negedge clk_sys);
      rv = rdata;
      rs = rresp;
      @(posedge clk_sys);
      rready <= 1'h0;
   endtask
   task automatic rdc(input sdb_idx_t i, input logic [15:0] e);
      rd(i);
      chk(rv, {16'h0000, e}, $sformatf("index %h", i));
   endtask
   // ===============================================================
   // clock, watchdog and tests
   initial begin
      clk_sys = 1'h0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      #1_000_000;
      mismatches++;
      close_out();
   end
   initial begin
      logic [15:0] v;
      mismatches = 0;
      checked = 0;
      rst_n = 1'h0;
      {awaddr, araddr, wdata} = '0;
      strb = 4'hF;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'h1;
      for (int i = 0; i < 6; i++) rdc(CIX[i], 16'h6000);
      rdc(SDB_IDX_RX_A_ERR, 16'h0000);
      rdc(SDB_IDX_RX_B_ERR, 16'h0000);
      rdc(SDB_IDX_IRQ_EN, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         v = 16'hBFFF - 16'(i * 5);
         wr(CIX[i], v);
         chk(32'(cfg[i]), 32'(v[12:0]), "cfg port");
      end
      for (int i = 0; i < 6; i++) begin
         v = 16'h6000 | (16'h1FFF - 16'(i * 5));
         rdc(CIX[i], v);
      end
      wr(16'h4400, 16'h1234);
      chk(32'(rs), 32'(SDB_RESP_DECERR), "write resp");
      rd(16'h4400);
      chk({rv[29:0], rs}, 32'(SDB_RESP_DECERR), "read resp");
      strb <= 4'h1;
      wr(CIX[2], 16'h0AAA);
      strb <= 4'hF;
      rdc(CIX[2], 16'h7FAA);
      wr(SDB_IDX_RX_A_ERR, 16'h0123);
      rdc(SDB_IDX_RX_A_ERR, 16'h0000);
      i_src.put(0, 1'h0);
      i_src.put(0, 1'h0);
      i_src.put(0, 1'h1);
      i_src.put(0, 1'h1);
      rdc(SDB_IDX_RX_A_ERR, 16'h0002);
      rdc(SDB_IDX_RX_A_CNT, 16'h0004);
      chk(32'(cnt[0]), 32'h0000_0004, "count a port");
      i_src.swap(0, 1'h0);
      rdc(SDB_IDX_RX_A_CNT, 16'h0000);
      i_src.put(0, 1'h1);
      rdc(SDB_IDX_RX_A_ERR, 16'h0002);
      i_src.swap(0, 1'h1);
      rdc(SDB_IDX_RX_A_ERR, 16'h0000);
      i_src.put(0, 1'h0);
      i_src.put(0, 1'h1);
      rdc(SDB_IDX_RX_A_ERR, 16'h0002);
      for (int i = 0; i < 3; i++) i_src.put(1, 1'h0);
      i_src.put(1, 1'h1);
      i_src.put(1, 1'h1);
      rdc(SDB_IDX_RX_B_ERR, 16'h0003);
      wr(SDB_IDX_DMA_CTRL, 16'h0001);
      rdc(SDB_IDX_RX_B_ERR, 16'h0000);
      rdc(SDB_IDX_RX_B_CNT, 16'h0000);
      chk(32'(dma_rsts), 32'h0000_0001, "dma reset pulses");
      i_src.put(1, 1'h0);
      rdc(SDB_IDX_RX_B_CNT, 16'h0001);
      chk(32'(cnt[1]), 32'h0000_0001, "count b port");
      i_src.put(1, 1'h1);
      rdc(SDB_IDX_RX_B_ERR, 16'h0001);
      wr(SDB_IDX_PEND_CLR, 16'h7FFF);
      for (int k = 0; k < SDB_IRQ_W; k++) begin
         v = 16'h0001 << k;
         wr(SDB_IDX_IRQ_EN, ~v);
         i_src.ev(k);
         rdc(SDB_IDX_PEND, v);
         @(negedge clk_sys);
         chk(32'(irq), 32'h0000_0000, "irq masked");
         wr(SDB_IDX_IRQ_EN, v);
         rdc(SDB_IDX_IRQ_EN, v);
         @(negedge clk_sys);
         chk(32'(irq), 32'h0000_0001, "irq");
         wr(SDB_IDX_PEND_CLR, v);
         @(negedge clk_sys);
         chk(32'(irq), 32'h0000_0000, "irq cleared");
      end
      close_out();
   end
endmodule
`default_nettype wire
